// [hdl/cmd_port_pkg.sv]
/*
 * Shared constants and types for the two-wire slave command port.
 * Assumes a 200 MHz core clock; nothing else is needed from the surroundings.
 */
package cmd_port_pkg;

    // ************************************************************
    // Command codes
    // ************************************************************
    localparam logic [7:0] CMD_ADDR_REG   = 8'h0D;
    localparam logic [7:0] CMD_RANGE_REG  = 8'h37;
    localparam logic [7:0] CMD_COMMIT_NV  = 8'h3F;

    // ************************************************************
    // Field layouts and reset values
    // ************************************************************
    localparam int         ADDR_REG_W     = 5;
    localparam int         SEL_LSB        = 0;
    localparam int         SEL_W          = 3;
    localparam int         COMMIT_BIT     = 3;
    localparam logic [4:0] ADDR_REG_RESET = 5'h00;
    localparam int         RANGE_W        = 14;
    localparam int         TYPE_LSB       = 4;
    localparam int         DIR_BIT        = 0;
    localparam int         BITS_PER_BYTE  = 8;
    localparam logic [3:0] ACK_BIT_COUNT  = 4'h9;
    // Arbitrary neutral device-type code, not a real part's
    localparam logic [3:0] DEVICE_TYPE_DFLT = 4'h6;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CORE_CLK_KHZ        = 200000;
    localparam int NV_WRITE_TIME_MS    = 10;
    localparam int NV_WRITE_CYCLES_DFLT = NV_WRITE_TIME_MS * CORE_CLK_KHZ;

    typedef logic [ADDR_REG_W-1:0] addr_reg_t;
    typedef logic [RANGE_W-1:0]    range_t;

    typedef enum logic [5:0] {
        ST_IDLE   = 6'b00_0001,
        ST_ADDR   = 6'b00_0010,
        ST_CMD    = 6'b00_0100,
        ST_WDATA  = 6'b00_1000,
        ST_RDATA  = 6'b01_0000,
        ST_IGNORE = 6'b10_0000
    } port_state_t;

endpackage

// [hdl/commit_if.sv]
/*
 * Carrier between the command engine and the nonvolatile store.
 * Assumes both ends run on core_clk.
 */
`timescale 1ns/1ps
interface commit_if;
    import cmd_port_pkg::*;
    logic      req;
    addr_reg_t image;
    logic      busy;
    addr_reg_t stored;

    modport engine (output req, output image, input busy, input stored);
    modport store  (input req, input image, output busy, output stored);
endinterface // commit_if

// [hdl/nv_store.sv]
/*
 * Nonvolatile store: latches the committed settings image and holds busy
 * for the programming time. Assumes req is a one-cycle pulse on core_clk.
 */
`timescale 1ns/1ps
module nv_store #(
    parameter int WRITE_CYCLES = cmd_port_pkg::NV_WRITE_CYCLES_DFLT
)(
    input  wire logic core_clk,
    input  wire logic rstn,
    input  wire logic clkEn,
    commit_if.store   nv
);
    import cmd_port_pkg::*;

    if (WRITE_CYCLES < 1) begin : g_chk
        $error("nv_store: WRITE_CYCLES must be at least 1");
    end

    logic [31:0] count_r;

    // ************************************************************
    // Programming timer and stored image
    // ************************************************************
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            nv.busy   <= 1'b0;
            nv.stored <= ADDR_REG_RESET;
            count_r   <= 32'h0000_0000;
        end
        else if (clkEn)
        begin
            if (nv.req && !nv.busy)
            begin
                nv.busy   <= 1'b1;
                nv.stored <= nv.image;
                count_r   <= 32'(WRITE_CYCLES - 1);
            end
            else if (nv.busy)
            begin
                if (count_r == 32'h0000_0000)
                    nv.busy <= 1'b0;
                else
                    count_r <= count_r - 32'h0000_0001;
            end
        end
    end
endmodule // nv_store

// [hdl/two_wire_slave_cmd_port.sv]
/*
 * Two-wire slave port with its command decoding: device-address register,
 * read-only range register and the nonvolatile commit command.
 * Assumes sclClk is the bus SCL wire itself, sclPin/sdaPin are the same
 * wires seen as levels, and the bench resolves SDA from sdaOeN (low = pull low).
 */
`timescale 1ns/1ps
module two_wire_slave_cmd_port #(
    parameter int         NV_WRITE_CYCLES = cmd_port_pkg::NV_WRITE_CYCLES_DFLT,
    parameter logic [3:0] DEVICE_TYPE     = cmd_port_pkg::DEVICE_TYPE_DFLT
)(
    input  wire logic                  core_clk,
    input  wire logic                  rstn,
    input  wire logic                  clkEn,
    input  wire logic                  sclClk,
    input  wire logic                  sclPin,
    input  wire logic                  sdaPin,
    input  wire cmd_port_pkg::range_t  rangeValue,
    output logic                       sdaOeN,
    output logic [2:0]                 deviceSelect,
    output logic                       commitMode,
    output logic                       nvBusy,
    output cmd_port_pkg::addr_reg_t    nvImage
);
    import cmd_port_pkg::*;

    if (NV_WRITE_CYCLES < 1) begin : g_chk
        $error("two_wire_slave_cmd_port: NV_WRITE_CYCLES must be at least 1");
    end

    port_state_t state_r;
    logic        sclS1_r;
    logic        sclS2_r;
    logic        sdaS1_r;
    logic        sdaS2_r;
    logic        sclD_r;
    logic        sdaD_r;
    logic [7:0]  rxShift_r;
    logic [7:0]  rxMeta_r;
    logic [7:0]  rxWord_r;
    logic [3:0]  bitCnt_r;
    logic [7:0]  byteIdx_r;
    logic [7:0]  cmd_r;
    logic        readDir_r;
    logic        ackGiven_r;
    logic        masterNack_r;
    logic        pending_r;
    logic        commitReq_r;
    addr_reg_t   addrReg_r;

    logic        sclRise;
    logic        sclFall;
    logic        startSeen;
    logic        stopSeen;
    logic        byteDone;
    logic        ackDone;
    logic        addrMatch;
    logic        ackNow;
    logic        addrWrite;
    logic [7:0]  txFirst;
    logic [7:0]  txCur;
    logic [7:0]  txNext;

    commit_if nvBus ();

    // ************************************************************
    // Link domain: receive shift register on SCL
    // ************************************************************
    // Sampling on the SCL rising edge is the bus's own data-valid point.
    always_ff @(posedge sclClk)
    begin
        rxShift_r <= {rxShift_r[6:0], sdaPin};
    end

    // ************************************************************
    // Core domain: pin synchronisers and received word
    // ************************************************************
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            sclS1_r <= 1'b1;
            sclS2_r <= 1'b1;
            sdaS1_r <= 1'b1;
            sdaS2_r <= 1'b1;
            sclD_r  <= 1'b1;
            sdaD_r  <= 1'b1;
        end
        else if (clkEn)
        begin
            // Oversampling on core_clk serves any SCL rate far below it
            sclS1_r <= sclPin;
            sclS2_r <= sclS1_r;
            sdaS1_r <= sdaPin;
            sdaS2_r <= sdaS1_r;
            sclD_r  <= sclS2_r;
            sdaD_r  <= sdaS2_r;
        end
    end

    // The shift register is quiet through SCL low, long before the byte is used
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            rxMeta_r <= 8'h00;
            rxWord_r <= 8'h00;
        end
        else if (clkEn)
        begin
            rxMeta_r <= rxShift_r;
            rxWord_r <= rxMeta_r;
        end
    end

    // ************************************************************
    // Bus events
    // ************************************************************
    assign sclRise   = sclS2_r && !sclD_r;
    assign sclFall   = !sclS2_r && sclD_r;
    assign startSeen = sclS2_r && sclD_r && sdaD_r && !sdaS2_r;
    assign stopSeen  = sclS2_r && sclD_r && !sdaD_r && sdaS2_r;
    assign byteDone  = sclFall && (bitCnt_r == 4'(BITS_PER_BYTE));
    assign ackDone   = sclFall && (bitCnt_r == ACK_BIT_COUNT);

    assign addrMatch = (rxWord_r[7:TYPE_LSB] == DEVICE_TYPE) &&
                       (rxWord_r[3:1] == addrReg_r[SEL_LSB +: SEL_W]);

    always_comb
    begin
        case (state_r)
            ST_ADDR:  ackNow = addrMatch && !nvBus.busy;
            ST_CMD:   ackNow = !nvBus.busy;
            ST_WDATA: ackNow = !nvBus.busy;
            default:  ackNow = 1'b0;
        endcase
    end

    assign addrWrite = byteDone && ackNow && (state_r == ST_WDATA) &&
                       (cmd_r == CMD_ADDR_REG) && (byteIdx_r == 8'h00);

    // Read data for a command and byte position
    function automatic logic [7:0] txFor(input logic [7:0] cmd, input logic [7:0] idx,
                                         input addr_reg_t addr, input range_t range);
        logic [7:0] res;
        res = 8'h00;
        if (cmd == CMD_ADDR_REG && idx == 8'h00)
            res = {3'b000, addr};
        else if (cmd == CMD_RANGE_REG && idx == 8'h00)
            res = range[13:6];
        else if (cmd == CMD_RANGE_REG && idx == 8'h01)
            res = {range[4:0], 3'b000};
        return res;
    endfunction

    assign txFirst = txFor(cmd_r, 8'h00, addrReg_r, rangeValue);
    assign txCur   = txFor(cmd_r, byteIdx_r, addrReg_r, rangeValue);
    assign txNext  = txFor(cmd_r, byteIdx_r + 8'h01, addrReg_r, rangeValue);

    // ************************************************************
    // Transfer sequencer
    // ************************************************************
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            state_r      <= ST_IDLE;
            bitCnt_r     <= 4'h0;
            byteIdx_r    <= 8'h00;
            cmd_r        <= 8'h00;
            readDir_r    <= 1'b0;
            ackGiven_r   <= 1'b0;
            masterNack_r <= 1'b0;
        end
        else if (clkEn)
        begin
            if (startSeen)
            begin
                state_r  <= ST_ADDR;
                bitCnt_r <= 4'h0;
            end
            else if (stopSeen)
            begin
                state_r <= ST_IDLE;
            end
            else
            begin
                case (state_r)
                    ST_ADDR, ST_CMD, ST_WDATA, ST_RDATA:
                    begin
                        if (sclRise)
                            bitCnt_r <= bitCnt_r + 4'h1;
                        if (sclRise && state_r == ST_RDATA && bitCnt_r == 4'(BITS_PER_BYTE))
                            masterNack_r <= sdaS2_r;
                        if (byteDone)
                        begin
                            ackGiven_r <= ackNow;
                            if (state_r == ST_ADDR)
                                readDir_r <= rxWord_r[DIR_BIT];
                            if (state_r == ST_CMD && ackNow)
                                cmd_r <= rxWord_r;
                        end
                        if (ackDone)
                        begin
                            bitCnt_r <= 4'h0;
                            case (state_r)
                                ST_ADDR:
                                begin
                                    byteIdx_r <= 8'h00;
                                    if (!ackGiven_r)
                                        state_r <= ST_IGNORE;
                                    else if (readDir_r)
                                        state_r <= ST_RDATA;
                                    else
                                        state_r <= ST_CMD;
                                end
                                ST_CMD:
                                    state_r <= ackGiven_r ? ST_WDATA : ST_IGNORE;
                                ST_WDATA:
                                begin
                                    if (!ackGiven_r)
                                        state_r <= ST_IGNORE;
                                    else if (byteIdx_r != 8'hFF)
                                        byteIdx_r <= byteIdx_r + 8'h01;
                                end
                                default:
                                begin
                                    if (masterNack_r)
                                        state_r <= ST_IGNORE;
                                    else if (byteIdx_r != 8'hFF)
                                        byteIdx_r <= byteIdx_r + 8'h01;
                                end
                            endcase
                        end
                    end
                    ST_IGNORE: bitCnt_r <= 4'h0;
                    ST_IDLE:   bitCnt_r <= 4'h0;
                    default:   state_r  <= ST_IDLE;
                endcase
            end
        end
    end

    // ************************************************************
    // SDA driver: changes only just after SCL falls
    // ************************************************************
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            sdaOeN <= 1'b1;
        else if (clkEn)
        begin
            if (startSeen || stopSeen)
                sdaOeN <= 1'b1;
            else if (byteDone)
                sdaOeN <= (state_r == ST_RDATA) ? 1'b1 : !ackNow;
            else if (ackDone)
            begin
                if (state_r == ST_ADDR && ackGiven_r && readDir_r)
                    sdaOeN <= txFirst[7];
                else if (state_r == ST_RDATA && !masterNack_r)
                    sdaOeN <= txNext[7];
                else
                    sdaOeN <= 1'b1;
            end
            else if (sclFall && state_r == ST_RDATA && bitCnt_r != 4'h0 &&
                     bitCnt_r < 4'(BITS_PER_BYTE))
                sdaOeN <= txCur[3'(7 - bitCnt_r)];
            else if (state_r == ST_IGNORE || state_r == ST_IDLE)
                sdaOeN <= 1'b1;
        end
    end

    // ************************************************************
    // Device-address register
    // ************************************************************
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            addrReg_r <= ADDR_REG_RESET;
        else if (clkEn && addrWrite)
            addrReg_r <= rxWord_r[ADDR_REG_W-1:0];
    end

    // ************************************************************
    // Commit policy
    // ************************************************************
    // The commit fires when the transfer closes, so a burst of bytes costs one
    // nonvolatile cycle rather than one per byte.
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            pending_r   <= 1'b0;
            commitReq_r <= 1'b0;
        end
        else if (clkEn)
        begin
            commitReq_r <= 1'b0;
            if (startSeen || stopSeen)
            begin
                commitReq_r <= pending_r;
                pending_r   <= 1'b0;
            end
            else if (byteDone && ackNow)
            begin
                if (state_r == ST_CMD && rxWord_r == CMD_COMMIT_NV)
                    pending_r <= 1'b1;
                else if (addrWrite)
                    pending_r <= 1'b1;
                else if (state_r == ST_WDATA && !addrReg_r[COMMIT_BIT])
                    pending_r <= 1'b1;
            end
        end
    end

    assign nvBus.req   = commitReq_r;
    assign nvBus.image = addrReg_r;

    nv_store #(
        .WRITE_CYCLES (NV_WRITE_CYCLES)
    ) u_nv_store (
        .core_clk (core_clk),
        .rstn     (rstn),
        .clkEn    (clkEn),
        .nv       (nvBus)
    );

    // ************************************************************
    // Status outputs
    // ************************************************************
    assign deviceSelect = addrReg_r[SEL_LSB +: SEL_W];
    assign commitMode   = addrReg_r[COMMIT_BIT];
    assign nvBusy       = nvBus.busy;
    assign nvImage      = nvBus.stored;

endmodule // two_wire_slave_cmd_port

// [dv/two_wire_slave_cmd_port_sva.sv]
/* Concurrent checks on the two-wire slave command port's top ports.
   Assumes core_clk domain sampling; bound to every instance below. */
`timescale 1ns/1ps
module two_wire_slave_cmd_port_sva #(
    parameter int NV_WRITE_CYCLES = 50
)(
    input wire logic                    core_clk,
    input wire logic                    rstn,
    input wire logic                    sclPin,
    input wire logic                    sdaPin,
    input wire logic                    sdaOeN,
    input wire logic [2:0]              deviceSelect,
    input wire logic                    commitMode,
    input wire logic                    nvBusy,
    input wire cmd_port_pkg::addr_reg_t nvImage
);
    import cmd_port_pkg::*;
    int busyCnt_r;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // Run length of the programming time, checked when busy drops
    always_ff @(posedge core_clk)
    begin
        if (!rstn || !nvBusy)
            busyCnt_r <= 0;
        else
            busyCnt_r <= busyCnt_r + 1;
    end

    oe_edge_a: assert property ($changed(sdaOeN) |-> !sclPin && !$past(sclPin) && !$past(sclPin, 2))
        else $error("SDA drive changed outside the SCL low phase");
    ack_hold_a: assert property ($fell(sdaOeN) |-> !sdaOeN [*8] ##[0:1000] sdaOeN)
        else $error("SDA pull-down too short or never released");
    busy_nack_a: assert property (nvBusy |-> sdaOeN)
        else $error("SDA pulled low during nonvolatile write");
    busy_frozen_a: assert property (nvBusy && $past(nvBusy) |-> $stable(deviceSelect) && $stable(commitMode))
        else $error("Settings changed during nonvolatile write");
    commit_image_a: assert property ($rose(nvBusy) |-> nvImage[3:0] == {commitMode, deviceSelect})
        else $error("Committed image differs from live settings");
    busy_len_a: assert property ($fell(nvBusy) |-> busyCnt_r == NV_WRITE_CYCLES)
        else $error("Nonvolatile write time wrong");
    reset_vals_a: assert property ($rose(rstn) |-> sdaOeN && deviceSelect == 3'h0 && !commitMode && !nvBusy)
        else $error("Wrong values after reset");
    stop_release_a: assert property (sclPin && $rose(sdaPin) |-> sdaOeN [*8])
        else $error("SDA held after stop");
endmodule // two_wire_slave_cmd_port_sva

bind two_wire_slave_cmd_port two_wire_slave_cmd_port_sva #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) u_sva (
    .core_clk(core_clk), .rstn(rstn), .sclPin(sclPin), .sdaPin(sdaPin), .sdaOeN(sdaOeN),
    .deviceSelect(deviceSelect), .commitMode(commitMode), .nvBusy(nvBusy), .nvImage(nvImage));

// [dv/two_wire_master.sv]
/* Behavioural two-wire bus master: makes SCL, START, STOP and bytes.
   Assumes the bench resolves SDA with a pull-up; SCL idles high. */
`timescale 1ns/1ps
module two_wire_master (
    output logic      scl,
    output logic      sdaDrv,
    input  wire logic sda
);
    realtime halfT = 62.5;

    initial
    begin
        scl    = 1'b1;
        sdaDrv = 1'b1;
    end

    // Data moves in the low phase and is read mid-high
    task automatic bitx(input logic b, output logic r);
        #(halfT / 4) sdaDrv = b;
        #(halfT * 3 / 4) scl = 1'b1;
        #(halfT / 2) r = sda;
        #(halfT / 2) scl = 1'b0;
    endtask

    task automatic start();
        #(halfT) sdaDrv = 1'b0;
        #(halfT) scl = 1'b0;
    endtask

    task automatic rstart();
        #(halfT / 4) sdaDrv = 1'b1;
        #(halfT * 3 / 4) scl = 1'b1;
        #(halfT / 2) sdaDrv = 1'b0;
        #(halfT / 2) scl = 1'b0;
    endtask

    task automatic stop();
        #(halfT / 4) sdaDrv = 1'b0;
        #(halfT * 3 / 4) scl = 1'b1;
        #(halfT / 2) sdaDrv = 1'b1;
        #(halfT);
    endtask

    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitx(d[i], r);
        bitx(1'b1, r);
        ack = !r;
    endtask

    // Last byte gets a not-acknowledge so the slave lets go
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bitx(1'b1, r);
            d[i] = r;
        end
        bitx(last, r);
    endtask
endmodule // two_wire_master

// [dv/two_wire_slave_cmd_port_test.sv]
/* Self-checking bench for the two-wire slave command port.
   Assumes the master model owns SCL and SDA has a pull-up. */
`timescale 1ns/1ps
module two_wire_slave_cmd_port_test;
    import cmd_port_pkg::*;
    logic       core_clk;
    logic       rstn;
    logic       clkEn;
    range_t     rangeValue;
    logic       scl;
    logic       sdaDrv;
    logic       sdaOeN;
    logic [2:0] deviceSelect;
    logic       commitMode;
    logic       nvBusy;
    addr_reg_t  nvImage;
    logic       a;
    logic [7:0] d;
    int         errorCnt = 0;
    int         nTests = 0;
    wire logic  sda = (sdaOeN === 1'b0) ? 1'b0 : sdaDrv;

    two_wire_slave_cmd_port #(.NV_WRITE_CYCLES(400)) dut (
        .core_clk(core_clk), .rstn(rstn), .clkEn(clkEn), .sclClk(scl), .sclPin(scl), .sdaPin(sda),
        .rangeValue(rangeValue), .sdaOeN(sdaOeN), .deviceSelect(deviceSelect), .commitMode(commitMode),
        .nvBusy(nvBusy), .nvImage(nvImage));
    two_wire_master mst (.scl(scl), .sdaDrv(sdaDrv), .sda(sda));

    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        nTests++;
        if (seen !== exp)
        begin
            errorCnt++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic testDone();
        $display("Comparisons %0d, mismatches %0d", nTests, errorCnt);
        if (errorCnt == 0 && nTests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic addr(input logic [2:0] s, input logic rd, input logic exp);
        mst.wbyte({DEVICE_TYPE_DFLT, s, rd}, a);
        check({7'h00, a}, {7'h00, exp}, "address ack");
    endtask

    // Keeps every SCL edge and every master-driven SDA edge of a transfer off the core clock's rising edge
    task automatic align();
        @(negedge core_clk);
        #1;
    endtask

    task automatic wr(input logic [2:0] s, input logic [7:0] cmd, input logic [7:0] v, input int nd, input logic exp);
        align();
        mst.start();
        addr(s, 1'b0, exp);
        if (exp)
        begin
            mst.wbyte(cmd, a);
            check({7'h00, a}, 8'h01, "command ack");
            for (int i = 0; i < nd; i++)
            begin
                mst.wbyte(v, a);
                check({7'h00, a}, 8'h01, "data ack");
            end
        end
        mst.stop();
    endtask

    task automatic rd(input logic [2:0] s, input logic [7:0] cmd, input logic [7:0] e0, input logic [7:0] e1);
        align();
        mst.start();
        addr(s, 1'b0, 1'b1);
        mst.wbyte(cmd, a);
        mst.rstart();
        addr(s, 1'b1, 1'b1);
        mst.rbyte(1'b0, d);
        check(d, e0, "first read byte");
        mst.rbyte(1'b1, d);
        check(d, e1, "second read byte");
        mst.stop();
    endtask

    // Bounded wait on the busy flag; running out ends the run
    task automatic waitFor(input logic v);
        int i;
        i = 0;
        while (nvBusy !== v && i < 1000)
        begin
            @(negedge core_clk);
            i++;
        end
        if (nvBusy !== v)
        begin
            check({7'h00, nvBusy}, {7'h00, v}, "busy wait ran out");
            testDone();
        end
    endtask

    initial
    begin
        #200000;
        check(8'h00, 8'h01, "run ran out of time");
        testDone();
    end

    initial
    begin
        rstn = 1'b0;
        clkEn = 1'b1;
        rangeValue = 14'h2d5b;
        repeat (2) @(negedge core_clk);
        rstn = 1'b1;
        repeat (6) @(negedge core_clk);
        check({2'h0, sdaOeN, nvBusy, commitMode, deviceSelect}, 8'h20, "reset values");
        rd(3'h0, CMD_ADDR_REG, 8'h00, 8'h00);
        rd(3'h0, CMD_RANGE_REG, rangeValue[13:6], {rangeValue[4:0], 3'h0});
        wr(3'h5, CMD_ADDR_REG, 8'h00, 0, 1'b0);
        // Wrong type code: no ack, and the next byte is ignored too
        align();
        mst.start();
        mst.wbyte({~DEVICE_TYPE_DFLT, 3'h0, 1'b0}, a);
        check({7'h00, a}, 8'h00, "foreign type ack");
        mst.wbyte(CMD_ADDR_REG, a);
        check({7'h00, a}, 8'h00, "ignored byte ack");
        mst.stop();
        wr(3'h0, CMD_ADDR_REG, 8'hea, 2, 1'b1);
        waitFor(1'b1);
        check({3'h0, nvImage}, 8'h0a, "committed image");
        check({4'h0, commitMode, deviceSelect}, 8'h0a, "new select and mode");
        wr(3'h2, CMD_ADDR_REG, 8'h00, 0, 1'b0);
        waitFor(1'b0);
        rd(3'h2, CMD_ADDR_REG, 8'h0a, 8'h00);
        wr(3'h0, CMD_ADDR_REG, 8'h00, 0, 1'b0);
        wr(3'h2, 8'h08, 8'h55, 1, 1'b1);
        repeat (20) @(negedge core_clk);
        check({7'h00, nvBusy}, 8'h00, "no commit with mode set");
        wr(3'h2, CMD_COMMIT_NV, 8'h00, 0, 1'b1);
        waitFor(1'b1);
        waitFor(1'b0);
        mst.halfT = 250.0;
        wr(3'h2, CMD_ADDR_REG, 8'h01, 1, 1'b1);
        waitFor(1'b1);
        check({3'h0, nvImage}, 8'h01, "image after slow write");
        waitFor(1'b0);
        mst.halfT = 62.5;
        wr(3'h1, 8'h08, 8'h55, 1, 1'b1);
        waitFor(1'b1);
        waitFor(1'b0);
        testDone();
    end
endmodule // two_wire_slave_cmd_port_test
